/* design/fsas_pkg.sv */
package fsas_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int          WORD_BITS      = 16;
  localparam logic [5:0]  FRAME_BITS     = 6'h20;
  localparam logic [5:0]  X_MSB_CLK      = 6'h01;
  localparam logic [5:0]  Y_MSB_CLK      = 6'h11;
  localparam logic [5:0]  FS_HIGH_BY_CLK = 6'h20;

  //////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int CONV_TIME_NS    = 5750;
  localparam int SAMPLE_RATE_KHZ = 100;
  localparam int MIN_SCLK_KHZ    = 8300;
  // Longest time, rounded down
  localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
  // Conversion time rounded up, plus one cycle
  localparam int HOLD_CYCLES     =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int SAMPLE_CYCLES   =
    1000000 / (SAMPLE_RATE_KHZ * CLK_PERIOD_NS);
  // Longest serial clock period, rounded down
  localparam int SCLK_CYCLES     =
    1000000 / (MIN_SCLK_KHZ * CLK_PERIOD_NS);
  localparam int SCLK_HALF       = SCLK_CYCLES / 2;

  localparam logic [9:0] CONV_LAST   = 10'(CONV_CYCLES - 1);
  localparam logic [9:0] HOLD_MIN    = 10'(HOLD_CYCLES);
  localparam logic [9:0] SAMPLE_LAST = 10'(SAMPLE_CYCLES - 1);
  localparam logic [1:0] HALF_LAST   = 2'(SCLK_HALF - 1);

  //////////////////////////////////////////////////////////////////////////
  // Reset and idle levels
  localparam logic FS_IDLE   = 1'h1;
  localparam logic SCLK_IDLE = 1'h0;

  //////////////////////////////////////////////////////////////////////////
  // State machines
  typedef enum logic [1:0] {
    DEV_IDLE  = 2'h1,
    DEV_FRAME = 2'h2
  } fsas_dev_st_e;

  typedef enum logic [3:0] {
    CTL_IDLE  = 4'h1,
    CTL_SHIFT = 4'h2,
    CTL_TAIL  = 4'h4,
    CTL_SPARE = 4'h8
  } fsas_ctl_st_e;

  //////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised levels
  function automatic logic fsas_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : fsas_rise

  function automatic logic fsas_fall(input logic cur, input logic prev);
    return ~cur & prev;
  endfunction : fsas_fall

endpackage : fsas_pkg

/* design/fsas_link_if.sv */
`timescale 1ns/1ps
interface fsas_link_if;
  logic sclk;      // Serial clock, from controller
  logic fsync;     // Frame sync, from controller
  logic cmd_data;  // Command bits, to device
  logic pos_data;  // Position bits, to controller

  // Servo side
  modport dev_mp (
    input  sclk,
    input  fsync,
    input  cmd_data,
    output pos_data
  );

  // Scan controller side
  modport ctl_mp (
    output sclk,
    output fsync,
    output cmd_data,
    input  pos_data
  );
endinterface : fsas_link_if

/* design/fsas_dev.sv */
`timescale 1ns/1ps
module fsas_dev (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Serial link
  fsas_link_if.dev_mp      link,
  // Configuration
  input  wire logic        sync_en_i,
  // Converter results
  input  wire logic [15:0] adc_x_i,
  input  wire logic [15:0] adc_y_i,
  // Conversion status
  output logic             conv_start_o,
  output logic             sample_done_o,
  output logic             conv_busy_o,
  // Received command
  output logic [15:0]      cmd_x_o,
  output logic [15:0]      cmd_y_o,
  output logic             cmd_valid_o,
  output logic             fs_err_o
);

  //////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic                  sclk_s1;
    logic                  sclk_s2;
    logic                  sclk_s3;
    logic                  fs_s1;
    logic                  fs_s2;
    logic                  fs_s3;
    logic                  dat_s1;
    logic                  dat_s2;
    fsas_pkg::fsas_dev_st_e st;
    logic [5:0]            bit_cnt;
    logic [31:0]           rx_sh;
    logic [31:0]           tx_sh;
    logic                  pos_data;
    logic                  conv_busy;
    logic [9:0]            conv_cnt;
    logic [9:0]            tmr_cnt;
    logic                  conv_start;
    logic                  sample_done;
    logic [15:0]           pos_x;
    logic [15:0]           pos_y;
    logic [15:0]           cmd_x;
    logic [15:0]           cmd_y;
    logic                  cmd_valid;
    logic                  fs_err;
  } fsas_dev_s;

  localparam fsas_dev_s DEV_RST = '{
    sclk_s1:     fsas_pkg::SCLK_IDLE,
    sclk_s2:     fsas_pkg::SCLK_IDLE,
    sclk_s3:     fsas_pkg::SCLK_IDLE,
    fs_s1:       fsas_pkg::FS_IDLE,
    fs_s2:       fsas_pkg::FS_IDLE,
    fs_s3:       fsas_pkg::FS_IDLE,
    dat_s1:      1'h0,
    dat_s2:      1'h0,
    st:          fsas_pkg::DEV_IDLE,
    bit_cnt:     6'h00,
    rx_sh:       32'h0000_0000,
    tx_sh:       32'h0000_0000,
    pos_data:    1'h0,
    conv_busy:   1'h0,
    conv_cnt:    10'h000,
    tmr_cnt:     10'h000,
    conv_start:  1'h0,
    sample_done: 1'h0,
    pos_x:       16'h0000,
    pos_y:       16'h0000,
    cmd_x:       16'h0000,
    cmd_y:       16'h0000,
    cmd_valid:   1'h0,
    fs_err:      1'h0
  };

  fsas_dev_s r_reg;
  fsas_dev_s r_next;

  logic sclk_rise;
  logic sclk_fall;
  logic fs_rise;
  logic fs_fall;
  logic trig;

  //////////////////////////////////////////////////////////////////////////
  // Edges seen on the second and third stages
  assign sclk_rise = fsas_pkg::fsas_rise(r_reg.sclk_s2, r_reg.sclk_s3);
  assign sclk_fall = fsas_pkg::fsas_fall(r_reg.sclk_s2, r_reg.sclk_s3);
  assign fs_rise   = fsas_pkg::fsas_rise(r_reg.fs_s2, r_reg.fs_s3);
  assign fs_fall   = fsas_pkg::fsas_fall(r_reg.fs_s2, r_reg.fs_s3);

  // Conversion trigger source
  assign trig = sync_en_i ? fs_rise
                          : (r_reg.tmr_cnt == fsas_pkg::SAMPLE_LAST);

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    r_next = r_reg;

    // Pin synchronisers
    r_next.sclk_s1 = link.sclk;
    r_next.sclk_s2 = r_reg.sclk_s1;
    r_next.sclk_s3 = r_reg.sclk_s2;
    r_next.fs_s1   = link.fsync;
    r_next.fs_s2   = r_reg.fs_s1;
    r_next.fs_s3   = r_reg.fs_s2;
    r_next.dat_s1  = link.cmd_data;
    r_next.dat_s2  = r_reg.dat_s1;

    // One-cycle pulses default low
    r_next.conv_start  = 1'h0;
    r_next.sample_done = 1'h0;
    r_next.cmd_valid   = 1'h0;
    r_next.fs_err      = 1'h0;

    // Internal sample-rate timer, halted in sync mode
    if (sync_en_i) begin
      r_next.tmr_cnt = 10'h000;
    end else if (r_reg.tmr_cnt == fsas_pkg::SAMPLE_LAST) begin
      r_next.tmr_cnt = 10'h000;
    end else begin
      r_next.tmr_cnt = r_reg.tmr_cnt + 10'h001;
    end

    // Conversion: start, count, capture converter results
    if (r_reg.conv_busy) begin
      if (r_reg.conv_cnt == fsas_pkg::CONV_LAST) begin
        r_next.conv_busy   = 1'h0;
        r_next.sample_done = 1'h1;
        r_next.pos_x       = adc_x_i;
        r_next.pos_y       = adc_y_i;
      end else begin
        r_next.conv_cnt = r_reg.conv_cnt + 10'h001;
      end
    end else if (trig) begin
      r_next.conv_busy  = 1'h1;
      r_next.conv_start = 1'h1;
      r_next.conv_cnt   = 10'h000;
    end

    // Serial frame
    case (r_reg.st)
      fsas_pkg::DEV_IDLE: begin
        if (fs_fall) begin
          // Latest finished sample goes out
          r_next.st       = fsas_pkg::DEV_FRAME;
          r_next.bit_cnt  = 6'h00;
          r_next.tx_sh    = {r_reg.pos_x, r_reg.pos_y};
          r_next.pos_data = r_reg.pos_x[fsas_pkg::WORD_BITS-1];
        end
      end
      fsas_pkg::DEV_FRAME: begin
        if (sclk_fall) begin
          // Command bit taken on falling clock
          r_next.rx_sh   = {r_reg.rx_sh[30:0], r_reg.dat_s2};
          r_next.bit_cnt = r_reg.bit_cnt + 6'h01;
          if (r_reg.bit_cnt == fsas_pkg::FRAME_BITS - 6'h01) begin
            r_next.st        = fsas_pkg::DEV_IDLE;
            r_next.cmd_x     = r_reg.rx_sh[30:15];
            r_next.cmd_y     = {r_reg.rx_sh[14:0], r_reg.dat_s2};
            r_next.cmd_valid = 1'h1;
            // Sync must be high again at the last clock
            r_next.fs_err    = ~r_reg.fs_s2;
          end
        end else if (sclk_rise && (r_reg.bit_cnt != 6'h00)) begin
          // Return bit moves on the rising clock
          r_next.tx_sh    = {r_reg.tx_sh[30:0], 1'h0};
          r_next.pos_data = r_reg.tx_sh[30];
        end
      end
      default: begin
        r_next.st = fsas_pkg::DEV_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_reg <= DEV_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.pos_data  = r_reg.pos_data;
  assign conv_start_o   = r_reg.conv_start;
  assign sample_done_o  = r_reg.sample_done;
  assign conv_busy_o    = r_reg.conv_busy;
  assign cmd_x_o        = r_reg.cmd_x;
  assign cmd_y_o        = r_reg.cmd_y;
  assign cmd_valid_o    = r_reg.cmd_valid;
  assign fs_err_o       = r_reg.fs_err;

endmodule : fsas_dev

/* design/fsas_ctl.sv */
`timescale 1ns/1ps
module fsas_ctl (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Serial link
  fsas_link_if.ctl_mp      link,
  // Mode and request
  input  wire logic        sync_mode_i,
  input  wire logic        start_i,
  input  wire logic [15:0] cmd_x_i,
  input  wire logic [15:0] cmd_y_i,
  // Status and returned position
  output logic             busy_o,
  output logic [15:0]      pos_x_o,
  output logic [15:0]      pos_y_o,
  output logic             pos_valid_o
);

  //////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    fsas_pkg::fsas_ctl_st_e st;
    logic                  sclk;
    logic                  fs;
    logic                  dat;
    logic [1:0]            ph;
    logic [5:0]            n;
    logic [31:0]           tx;
    logic [31:0]           rx;
    logic [9:0]            hold_cnt;
    logic [9:0]            rate_cnt;
    logic                  pend;
    logic                  ret_s1;
    logic                  ret_s2;
    logic                  busy;
    logic [15:0]           pos_x;
    logic [15:0]           pos_y;
    logic                  pos_valid;
  } fsas_ctl_s;

  localparam fsas_ctl_s CTL_RST = '{
    st:        fsas_pkg::CTL_IDLE,
    sclk:      fsas_pkg::SCLK_IDLE,
    fs:        fsas_pkg::FS_IDLE,
    dat:       1'h0,
    ph:        2'h0,
    n:         6'h00,
    tx:        32'h0000_0000,
    rx:        32'h0000_0000,
    hold_cnt:  10'h000,
    rate_cnt:  10'h000,
    pend:      1'h0,
    ret_s1:    1'h0,
    ret_s2:    1'h0,
    busy:      1'h0,
    pos_x:     16'h0000,
    pos_y:     16'h0000,
    pos_valid: 1'h0
  };

  fsas_ctl_s r_reg;
  fsas_ctl_s r_next;

  logic go;
  logic hold_ok;
  logic launch;
  logic half_end;

  //////////////////////////////////////////////////////////////////////////
  // Frame requests: rate timer in sync mode, start pulse otherwise
  assign go = sync_mode_i ? (r_reg.rate_cnt == fsas_pkg::SAMPLE_LAST)
                          : start_i;
  assign hold_ok  = ~sync_mode_i
                  | (r_reg.hold_cnt >= fsas_pkg::HOLD_MIN);
  assign launch   = (r_reg.st == fsas_pkg::CTL_IDLE) & r_reg.pend & hold_ok;
  assign half_end = (r_reg.ph == fsas_pkg::HALF_LAST);

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    r_next = r_reg;
    r_next.ret_s1    = link.pos_data;
    r_next.ret_s2    = r_reg.ret_s1;
    r_next.pos_valid = 1'h0;
    r_next.pend      = (r_reg.pend & ~launch) | go;
    r_next.rate_cnt  = (go || !sync_mode_i) ? 10'h000
                                            : r_reg.rate_cnt + 10'h001;
    // Time since sync last rose, saturating
    if (!r_reg.fs) begin
      r_next.hold_cnt = 10'h000;
    end else if (r_reg.hold_cnt != 10'h3ff) begin
      r_next.hold_cnt = r_reg.hold_cnt + 10'h001;
    end
    r_next.ph = half_end ? 2'h0 : r_reg.ph + 2'h1;

    case (r_reg.st)
      fsas_pkg::CTL_IDLE: begin
        r_next.ph = 2'h0;
        if (launch) begin
          // Sync falls with the first rising clock
          r_next.st   = fsas_pkg::CTL_SHIFT;
          r_next.busy = 1'h1;
          r_next.fs   = 1'h0;
          r_next.sclk = 1'h1;
          r_next.n    = 6'h00;
          r_next.tx   = {cmd_x_i, cmd_y_i};
          r_next.dat  = cmd_x_i[fsas_pkg::WORD_BITS-1];
        end
      end
      fsas_pkg::CTL_SHIFT: begin
        if (half_end && r_reg.sclk) begin
          // Falling clock: device takes bit n+1
          r_next.sclk = 1'h0;
          r_next.n    = r_reg.n + 6'h01;
          if (r_reg.n == fsas_pkg::FRAME_BITS - 6'h01) begin
            r_next.st = fsas_pkg::CTL_TAIL;
          end
        end else if (half_end) begin
          // Rising clock: take return bit, move own data
          r_next.sclk = 1'h1;
          r_next.rx   = {r_reg.rx[30:0], r_reg.ret_s2};
          r_next.tx   = {r_reg.tx[30:0], 1'h0};
          r_next.dat  = r_reg.tx[30];
          if (r_reg.n == fsas_pkg::X_MSB_CLK) begin
            r_next.fs = 1'h1;
          end
        end
      end
      fsas_pkg::CTL_TAIL: begin
        if (half_end) begin
          r_next.st        = fsas_pkg::CTL_IDLE;
          r_next.busy      = 1'h0;
          r_next.fs        = 1'h1;
          r_next.pos_x     = r_reg.rx[30:15];
          r_next.pos_y     = {r_reg.rx[14:0], r_reg.ret_s2};
          r_next.pos_valid = 1'h1;
        end
      end
      default: begin
        r_next.st = fsas_pkg::CTL_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_reg <= CTL_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.sclk     = r_reg.sclk;
  assign link.fsync    = r_reg.fs;
  assign link.cmd_data = r_reg.dat;
  assign busy_o        = r_reg.busy;
  assign pos_x_o       = r_reg.pos_x;
  assign pos_y_o       = r_reg.pos_y;
  assign pos_valid_o   = r_reg.pos_valid;

endmodule : fsas_ctl

/* verification/fsas_asserts.sv */
`timescale 1ns/1ps
module fsas_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link signals
  input wire logic sclk_i,
  input wire logic fsync_i,
  input wire logic cmd_data_i,
  input wire logic pos_data_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  logic       act_reg;
  logic [4:0] nfall_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame tracker, from sync fall to the 32nd clock fall
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      act_reg   <= 1'h0;
      nfall_reg <= 5'h00;
    end else if ($fell(fsync_i)) begin
      act_reg   <= 1'h1;
      nfall_reg <= 5'h00;
    end else if (act_reg && $fell(sclk_i)) begin
      act_reg   <= (nfall_reg != 5'h1f);
      nfall_reg <= nfall_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link timing and framing
  chk_frame_opens: assert property ($fell(fsync_i) |-> $rose(sclk_i))
    else $error("clock did not start with the sync fall");
  chk_idle_quiet: assert property (!act_reg && fsync_i |-> !sclk_i)
    else $error("serial clock high outside a frame");
  chk_no_resync: assert property (act_reg |-> !$fell(fsync_i))
    else $error("sync fell again inside a frame");
  chk_half_period: assert property ($rose(sclk_i) |-> sclk_i[*3]
    ##1 !sclk_i)
    else $error("serial clock high time not three cycles");
  chk_data_on_rise: assert property ($changed(cmd_data_i)
    |-> $rose(sclk_i))
    else $error("command bit changed away from a clock rise");
  chk_ret_settled: assert property ($rose(sclk_i)
    |-> $stable(pos_data_i))
    else $error("position bit moved at the sampling rise");
  chk_frame_len: assert property ($fell(fsync_i) |-> ##189
    $fell(sclk_i) ##1 !sclk_i[*2])
    else $error("frame is not 32 clocks long");
  chk_sync_by_32: assert property (act_reg && nfall_reg == 5'h1f
    && $fell(sclk_i) |-> fsync_i)
    else $error("sync not high at clock 32");
  chk_sync_span: assert property ($fell(fsync_i) |-> !fsync_i[*3]
    ##[1:6] fsync_i)
    else $error("sync low span out of range");
endmodule : fsas_asserts

/* verification/tb_frame_synced_adc_sampling.sv */
`timescale 1ns/1ps
module tb_frame_synced_adc_sampling;
  logic        clk_i, rst_b_i, sync_en, sync_mode, start;
  logic [15:0] cmd_x, cmd_y, adc_x, adc_y, cx2, cy2;
  logic [15:0] cmd_x_o, cmd_y_o, pos_x_o, pos_y_o;
  logic        conv_start, sample_done, cmd_valid, fs_err;
  logic        pos_valid, cv2, fe2, fs_d, conv_busy, busy;
  logic [31:0] cap_cmd, cap_pos;
  logic [4:0]  ev;
  int          n_mismatch, num_checks, cyc, t_rise, t_prev;
  int          hi_cnt, hi_len, n_fe1, n_fe2;

  fsas_link_if link ();
  fsas_link_if link_err ();

  ////////////////////////////////////////////////////////////////////////////
  // Ends joined, plus a servo end on a rule-breaking link
  fsas_dev i_fsas_dev (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link.dev_mp),
    .sync_en_i(sync_en), .adc_x_i(adc_x), .adc_y_i(adc_y),
    .conv_start_o(conv_start), .sample_done_o(sample_done),
    .conv_busy_o(conv_busy), .cmd_x_o(cmd_x_o), .cmd_y_o(cmd_y_o),
    .cmd_valid_o(cmd_valid), .fs_err_o(fs_err));
  fsas_ctl i_fsas_ctl (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link.ctl_mp),
    .sync_mode_i(sync_mode), .start_i(start), .cmd_x_i(cmd_x),
    .cmd_y_i(cmd_y), .busy_o(busy), .pos_x_o(pos_x_o), .pos_y_o(pos_y_o),
    .pos_valid_o(pos_valid));
  fsas_dev i_fsas_dev_err (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .link(link_err.dev_mp), .sync_en_i(1'h0), .adc_x_i(adc_x),
    .adc_y_i(adc_y), .conv_start_o(), .sample_done_o(), .conv_busy_o(),
    .cmd_x_o(cx2), .cmd_y_o(cy2), .cmd_valid_o(cv2), .fs_err_o(fe2));
  fsas_asserts i_fsas_asserts (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .sclk_i(link.sclk), .fsync_i(link.fsync),
    .cmd_data_i(link.cmd_data), .pos_data_i(link.pos_data));

  assign ev = {cv2, pos_valid, sample_done, conv_start, cmd_valid};

  // Clock
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end

  // Cycle count, sync rise times, sync high spans, error pulses
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    fs_d <= link.fsync;
    if (link.fsync && !fs_d) begin
      t_prev <= t_rise;
      t_rise <= cyc;
    end
    hi_cnt <= link.fsync ? hi_cnt + 1 : 0;
    if (!link.fsync && fs_d) hi_len <= hi_cnt;
    n_fe1 <= n_fe1 + int'(fs_err);
    n_fe2 <= n_fe2 + int'(fe2);
  end

  // Wire capture: commands on falls, positions on rises
  always @(negedge link.sclk) cap_cmd <= {cap_cmd[30:0], link.cmd_data};
  always @(posedge link.sclk) cap_pos <= {cap_pos[30:0], link.pos_data};

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // Bounded wait for one event bit, sampled at the falling edge
  task automatic wait_ev(input int k);
    int i;
    i = 0;
    @(negedge clk_i);
    while (ev[k] !== 1'h1 && i < 1000) begin
      @(negedge clk_i);
      i++;
    end
    if (i >= 1000) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : wait_ev

  // Hand-made frame at 160 ns per clock; low keeps sync down throughout
  task automatic bang(input logic low, input logic [31:0] w);
    @(posedge clk_i);
    link_err.fsync <= 1'h0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 32; i++) begin
      link_err.sclk <= 1'h1;
      link_err.cmd_data <= w[31-i];
      if (i == 1) link_err.fsync <= ~low;
      repeat (4) @(posedge clk_i);
      link_err.sclk <= 1'h0;
      if (i < 31) repeat (4) @(posedge clk_i);
    end
    wait_ev(4);
    @(posedge clk_i);
    link_err.fsync <= 1'h1;
    link_err.cmd_data <= ~w[0];
  endtask : bang

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_bad_sync();
    bang(1'h1, 32'ha5c30ff1);
    @(negedge clk_i);
    check({cx2, cy2}, 32'ha5c30ff1);
    check(n_fe2, 1);
    bang(1'h0, 32'h1e2d3c4b);
    @(negedge clk_i);
    check({cx2, cy2}, 32'h1e2d3c4b);
    check(n_fe2, 1);
  endtask : t_bad_sync

  task automatic t_manual();
    int t0;
    @(posedge clk_i);
    adc_x <= 16'hc3a5;
    adc_y <= 16'h5a3c;
    wait_ev(1);
    t0 = cyc;
    wait_ev(2);
    @(posedge clk_i);
    start <= 1'h1;
    cmd_x <= 16'h8001;
    cmd_y <= 16'h7ffe;
    @(posedge clk_i);
    start <= 1'h0;
    repeat (2) @(negedge clk_i);
    check(busy, 1'h1);
    wait_ev(3);
    check(busy, 1'h0);
    check({pos_x_o, pos_y_o}, 32'hc3a55a3c);
    check({1'h0, cap_pos[30:0]}, 32'h61d2ad1e);
    check(cap_cmd, 32'h80017ffe);
    repeat (4) @(negedge clk_i);
    check({cmd_x_o, cmd_y_o}, 32'h80017ffe);
    wait_ev(1);
    check(cyc - t0, 500);
  endtask : t_manual

  task automatic t_sync();
    int d;
    int t0;
    @(posedge clk_i);
    sync_en <= 1'h1;
    sync_mode <= 1'h1;
    wait_ev(1);
    check(conv_busy, 1'h1);
    d = cyc - t_rise;
    check((d >= 1 && d <= 6), 1'h1);
    t0 = cyc;
    @(posedge clk_i);
    adc_x <= 16'h1234;
    adc_y <= 16'hfedc;
    wait_ev(2);
    check(cyc - t0, 287);
    check(conv_busy, 1'h0);
    @(posedge clk_i);
    adc_x <= 16'h0f0f;
    adc_y <= 16'hf0f0;
    wait_ev(3);
    check({pos_x_o, pos_y_o}, 32'h1234fedc);
    check((hi_len >= 288), 1'h1);
    check(t_rise - t_prev, 500);
  endtask : t_sync

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b_i = 1'h0;
    {sync_en, sync_mode, start} = 3'h0;
    {cmd_x, cmd_y, adc_x, adc_y} = 64'h0;
    link_err.sclk = 1'h0;
    link_err.fsync = 1'h1;
    link_err.cmd_data = 1'h0;
    {n_mismatch, num_checks, cyc, t_rise, t_prev} = '0;
    {hi_cnt, hi_len, n_fe1, n_fe2} = '0;
    fs_d = 1'h1;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'h1;
    t_bad_sync();
    t_manual();
    t_sync();
    check(n_fe1, 0);
    give_verdict();
  end
endmodule : tb_frame_synced_adc_sampling
